// [rtl/pfc_defs.svh]
// Offsets, field codes, limits and bus answers of the packet field codec.
// Assumes a 250 MHz single clock; no timing counts are needed.
`ifndef PFC_DEFS_SVH
`define PFC_DEFS_SVH
// Register byte offsets
`define PFC_A_CTRL 8'h00
`define PFC_A_STAT 8'h04
`define PFC_A_HDR 8'h08
`define PFC_A_DIAG 8'h0c
`define PFC_A_LENS 8'h10
`define PFC_A_ENCCFG 8'h14
`define PFC_A_ENCOUT 8'h18
// Control bits
`define PFC_CTRL_LOCAL 0
`define PFC_CTRL_FAST 1
`define PFC_CTRL_CLR 2
`define PFC_CTRL_RST 2'h0
// Format identifier codes (bits 6 and 5 of octet 1)
`define PFC_GFI_M8 2'h1
`define PFC_GFI_M128 2'h2
// Packet type octets
`define PFC_TY_INT 8'h23
`define PFC_TY_CLR 8'h13
`define PFC_TY_RR8 5'h01
`define PFC_TY_RNR8 5'h05
`define PFC_TY_RR128 8'h01
`define PFC_TY_RNR128 8'h05
// Clearing cause and diagnostic mapping
`define PFC_CAUSE_CONG 8'h05
`define PFC_DG_LOW_MAX 8'h6f
`define PFC_DG_SAME_MAX 8'h7f
`define PFC_DG_LOW 8'h72
`define PFC_DG_HIGH 8'h71
// Field limits
`define PFC_FAC_MAX 7'h6d
`define PFC_INT_MAX 8'h20
`define PFC_CUD_MAX 8'h80
`define PFC_BCD_MAX 4'h9
// Bus answers
`define PFC_RESP_OK 2'h0
`define PFC_RESP_ERR 2'h2
`endif

// [rtl/pfc_pkg.sv]
// Types shared by the packet field codec files.
// Assumes nothing beyond a SystemVerilog compiler.
package pfc_pkg;
  // Parser walk states, one-hot
  typedef enum logic [10:0] {
    PFC_ST_HDR = 11'h001, PFC_ST_CAUSE = 11'h002, PFC_ST_DIAG = 11'h004,
    PFC_ST_ALEN = 11'h008, PFC_ST_ADDR = 11'h010, PFC_ST_ULEN = 11'h020,
    PFC_ST_UTIL = 11'h040, PFC_ST_FLEN = 11'h080, PFC_ST_FAC = 11'h100,
    PFC_ST_PAY = 11'h200, PFC_ST_FIXED = 11'h400
  } pfc_st_e;
  // Packet kinds found in octet 3
  typedef enum logic [2:0] {
    PFC_TY_NONE = 3'h0, PFC_TY_DATA = 3'h1, PFC_TY_INTR = 3'h2,
    PFC_TY_CLEAR = 3'h3, PFC_TY_RXRDY = 3'h4, PFC_TY_RXNRDY = 3'h5
  } pfc_ty_e;
  // Header fields of data and flow control packets
  typedef struct packed {
    logic q;
    logic d;
    logic mod128;
    logic more;
    logic [6:0] pr;
    logic [6:0] ps;
  } pfc_hdr_s;
  // Trailer and payload lengths
  typedef struct packed {
    logic [3:0] calling;
    logic [3:0] called;
    logic [5:0] util;
    logic [6:0] fac;
    logic [7:0] pay;
  } pfc_lens_s;
  // Encoder settings
  typedef struct packed {
    logic [3:0] calling;
    logic [3:0] called;
    pfc_hdr_s h;
  } pfc_enc_s;
endpackage

// [rtl/pfc_diag_map.sv]
// Clearing diagnostic remapper with a registered result.
// Assumes cause and diagnostic are steady from the codec registers.
`timescale 1ns/1ps
`include "pfc_defs.svh"
module pfc_diag_map (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Cause, original diagnostic, event origin
  input wire logic [7:0] cause,
  input wire logic [7:0] diagIn,
  input wire logic localEvt,
  // Diagnostic as passed on
  output logic [7:0] diagOut
);
  logic remap;
  assign remap = (cause == `PFC_CAUSE_CONG) && !localEvt;
  // Congestion from a remote event folds the code into three bands
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      diagOut <= 8'h00;
    end else if (!remap || diagIn == 8'h00) begin
      diagOut <= diagIn;
    end else if (diagIn <= `PFC_DG_LOW_MAX) begin
      diagOut <= `PFC_DG_LOW;
    end else if (diagIn <= `PFC_DG_SAME_MAX) begin
      diagOut <= diagIn;
    end else begin
      diagOut <= `PFC_DG_HIGH;
    end
  end
  // ==========================================================
  // Checks
  a_diag_low_band: assert property (@(posedge mclk) disable iff (!arst_n)
    remap && diagIn != 8'h00 && diagIn <= `PFC_DG_LOW_MAX |=> diagOut == `PFC_DG_LOW)
    else $error("low diagnostic band not mapped");
  a_diag_high_band: assert property (@(posedge mclk) disable iff (!arst_n)
    remap && diagIn[7] |=> diagOut == `PFC_DG_HIGH)
    else $error("high diagnostic band not mapped");
  a_diag_pass_through: assert property (@(posedge mclk) disable iff (!arst_n)
    !remap |=> diagOut == $past(diagIn))
    else $error("diagnostic altered without remote congestion");
endmodule // pfc_diag_map

// [rtl/pfc_codec.sv]
// Packet field codec: walks one packet-layer packet from an octet stream,
// exposes its fields over AXI4-Lite, and encodes headers from settings.
// Assumes the octet source runs on mclk and holds data while not ready.
//
// Overview of operation
// - Remote congestion diagnostic: 0,112-127 kept, 1-111 to 114, 128-255 to 113.
// - Remap only for congestion cause and a non-local event, else pass.
// - Address length octet low nibble is called length in semi-octets.
// - Address length octet high nibble is calling length in semi-octets.
// - Utility length octet present implies address length octet present.
// - Address digits BCD, two per octet, high first, odd pad zero.
// - Redirected clear carries final destination in the address field.
// - Utility length in bits 6-1, bits 8 and 7 zero.
// - Utility length octet present whenever facility length octet is.
// - Utility field whole octets, at most 63, longer flagged.
// - Facility length in bits 7-1, bit 8 zero.
// - Facility length octet present whenever clear user data is.
// - Facility field at most 109 octets, carried opaque.
// - Clear user data only with fast select, 0 to 128 octets.
// - Format code 0001 modulo 8, 0010 modulo 128, selects layout.
// - Data qualifier flag is octet 1 bit 8.
// - Data delivery confirmation flag is octet 1 bit 7.
// - Modulo 8 data receive number in octet 3 bits 8-6.
// - Send number octet 3 bits 4-2 (mod 8) or 8-2 (mod 128).
// - More flag octet 3 bit 5 (mod 8) or octet 4 bit 1.
// - Data user data after octet 3 (mod 8) or octet 4.
// - Interrupt user data from octet 4, 1 to 32 octets, else flagged.
// - Flow control receive number octet 3 bits 8-6 or octet 4 bits 8-2.
`timescale 1ns/1ps
`include "pfc_defs.svh"
module pfc_codec (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Packet octet stream
  input wire logic inValid,
  input wire logic [7:0] inData,
  input wire logic inLast,
  output logic inReady,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  pfc_pkg::pfc_st_e st_reg, st_next;
  pfc_pkg::pfc_ty_e ty_reg, tyNow, tyEnd;
  pfc_pkg::pfc_hdr_s hdr_reg;
  pfc_pkg::pfc_lens_s lens_reg;
  pfc_pkg::pfc_enc_s enc_reg;
  logic [7:0] idx_reg, rem_reg, rem_next, cause_reg, diag_reg, diagOut, payEnd;
  logic [4:0] semiSum;
  logic [1:0] ctrl_reg;
  logic [7:0] awAddr_reg;
  logic [31:0] wData_reg, wMask;
  logic [3:0] wStrb_reg;
  logic accept, endOk, done_reg, done_next, clrPulse, wrGo, wrHit, rdHit;
  logic fmtErr_reg, lenErr_reg, intErr_reg, cudErr_reg;
  logic fmtSet, lenSet, intSet, cudSet;
  logic [31:0] rdWord;

  assign accept = inValid && inReady;
  assign semiSum = {1'b0, inData[7:4]} + {1'b0, inData[3:0]};

  // ==========================================================
  // Packet type decode
  // Type octet is read under the layout chosen by the format code
  always_comb begin
    tyNow = pfc_pkg::PFC_TY_NONE;
    if (!inData[0]) begin
      tyNow = pfc_pkg::PFC_TY_DATA;
    end else if (inData == `PFC_TY_INT) begin
      tyNow = pfc_pkg::PFC_TY_INTR;
    end else if (inData == `PFC_TY_CLR) begin
      tyNow = pfc_pkg::PFC_TY_CLEAR;
    end else if (hdr_reg.mod128) begin
      if (inData == `PFC_TY_RR128) tyNow = pfc_pkg::PFC_TY_RXRDY;
      if (inData == `PFC_TY_RNR128) tyNow = pfc_pkg::PFC_TY_RXNRDY;
    end else begin
      if (inData[4:0] == `PFC_TY_RR8) tyNow = pfc_pkg::PFC_TY_RXRDY;
      if (inData[4:0] == `PFC_TY_RNR8) tyNow = pfc_pkg::PFC_TY_RXNRDY;
    end
  end

  // ==========================================================
  // Field walk
  // Zero-length fields are skipped so the next length octet, or the payload after facilities, is expected
  always_comb begin
    st_next = st_reg;
    rem_next = rem_reg;
    case (st_reg)
      pfc_pkg::PFC_ST_HDR: begin
        if (idx_reg == 8'h02) begin
          case (tyNow)
            pfc_pkg::PFC_TY_DATA: st_next = hdr_reg.mod128 ? st_reg : pfc_pkg::PFC_ST_PAY;
            pfc_pkg::PFC_TY_INTR: st_next = pfc_pkg::PFC_ST_PAY;
            pfc_pkg::PFC_TY_CLEAR: st_next = pfc_pkg::PFC_ST_CAUSE;
            pfc_pkg::PFC_TY_NONE: st_next = pfc_pkg::PFC_ST_PAY;
            default: st_next = hdr_reg.mod128 ? st_reg : pfc_pkg::PFC_ST_FIXED;
          endcase
        end else if (idx_reg == 8'h03) begin
          st_next = (ty_reg == pfc_pkg::PFC_TY_DATA) ? pfc_pkg::PFC_ST_PAY
                                                     : pfc_pkg::PFC_ST_FIXED;
        end
      end
      pfc_pkg::PFC_ST_CAUSE: st_next = pfc_pkg::PFC_ST_DIAG;
      pfc_pkg::PFC_ST_DIAG: st_next = pfc_pkg::PFC_ST_ALEN;
      pfc_pkg::PFC_ST_ALEN: begin
        rem_next = {3'h0, semiSum};
        st_next = (semiSum == 5'h00) ? pfc_pkg::PFC_ST_ULEN : pfc_pkg::PFC_ST_ADDR;
      end
      pfc_pkg::PFC_ST_ADDR: begin
        rem_next = (rem_reg <= 8'h02) ? 8'h00 : rem_reg - 8'h02;
        if (rem_reg <= 8'h02) st_next = pfc_pkg::PFC_ST_ULEN;
      end
      pfc_pkg::PFC_ST_ULEN: begin
        rem_next = {2'h0, inData[5:0]};
        st_next = (inData[5:0] == 6'h00) ? pfc_pkg::PFC_ST_FLEN : pfc_pkg::PFC_ST_UTIL;
      end
      pfc_pkg::PFC_ST_UTIL: begin
        rem_next = rem_reg - 8'h01;
        if (rem_reg == 8'h01) st_next = pfc_pkg::PFC_ST_FLEN;
      end
      pfc_pkg::PFC_ST_FLEN: begin
        rem_next = {1'b0, inData[6:0]};
        st_next = (inData[6:0] == 7'h00) ? pfc_pkg::PFC_ST_PAY : pfc_pkg::PFC_ST_FAC;
      end
      pfc_pkg::PFC_ST_FAC: begin
        rem_next = rem_reg - 8'h01;
        if (rem_reg == 8'h01) st_next = pfc_pkg::PFC_ST_PAY;
      end
      default: st_next = st_reg;
    endcase
  end

  // A packet may end only at a field boundary; a length octet may be absent
  // but never one whose field was announced
  assign endOk = (st_next == pfc_pkg::PFC_ST_PAY) || (st_next == pfc_pkg::PFC_ST_ALEN)
              || (st_next == pfc_pkg::PFC_ST_ULEN) || (st_next == pfc_pkg::PFC_ST_FLEN)
              || (st_next == pfc_pkg::PFC_ST_FIXED);
  assign tyEnd = (st_reg == pfc_pkg::PFC_ST_HDR && idx_reg == 8'h02) ? tyNow : ty_reg;
  assign payEnd = lens_reg.pay + {7'h00, st_reg == pfc_pkg::PFC_ST_PAY && lens_reg.pay != 8'hff};

  // State, octet index and field countdown
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= pfc_pkg::PFC_ST_HDR;
      idx_reg <= 8'h00;
      rem_reg <= 8'h00;
    end else if (accept) begin
      st_reg <= inLast ? pfc_pkg::PFC_ST_HDR : st_next;
      idx_reg <= inLast ? 8'h00 : (idx_reg == 8'hff ? idx_reg : idx_reg + 8'h01);
      rem_reg <= rem_next;
    end
  end

  // Header fields; octet 1 restarts the record
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hdr_reg <= '0;
      ty_reg <= pfc_pkg::PFC_TY_NONE;
    end else if (accept && st_reg == pfc_pkg::PFC_ST_HDR) begin
      if (idx_reg == 8'h00) begin
        hdr_reg <= '0;
        hdr_reg.q <= inData[7];
        hdr_reg.d <= inData[6];
        hdr_reg.mod128 <= (inData[5:4] == `PFC_GFI_M128);
        ty_reg <= pfc_pkg::PFC_TY_NONE;
      end else if (idx_reg == 8'h02) begin
        ty_reg <= tyNow;
        if (tyNow == pfc_pkg::PFC_TY_DATA && !hdr_reg.mod128) begin
          hdr_reg.pr <= {4'h0, inData[7:5]};
          hdr_reg.more <= inData[4];
          hdr_reg.ps <= {4'h0, inData[3:1]};
        end else if (tyNow == pfc_pkg::PFC_TY_DATA) begin
          hdr_reg.ps <= inData[7:1];
        end else if (tyNow == pfc_pkg::PFC_TY_RXRDY || tyNow == pfc_pkg::PFC_TY_RXNRDY) begin
          hdr_reg.pr <= hdr_reg.mod128 ? 7'h00 : {4'h0, inData[7:5]};
        end
      end else if (idx_reg == 8'h03) begin
        hdr_reg.pr <= inData[7:1];
        if (ty_reg == pfc_pkg::PFC_TY_DATA) hdr_reg.more <= inData[0];
      end
    end
  end

  // Clearing cause, diagnostic and length fields
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cause_reg <= 8'h00;
      diag_reg <= 8'h00;
      lens_reg <= '0;
    end else if (accept) begin
      case (st_reg)
        pfc_pkg::PFC_ST_HDR: if (idx_reg == 8'h00) lens_reg <= '0;
        pfc_pkg::PFC_ST_CAUSE: cause_reg <= inData;
        pfc_pkg::PFC_ST_DIAG: diag_reg <= inData;
        pfc_pkg::PFC_ST_ALEN: begin
          lens_reg.called <= inData[3:0];
          lens_reg.calling <= inData[7:4];
        end
        pfc_pkg::PFC_ST_ULEN: lens_reg.util <= inData[5:0];
        pfc_pkg::PFC_ST_FLEN: lens_reg.fac <= inData[6:0];
        pfc_pkg::PFC_ST_PAY: if (lens_reg.pay != 8'hff) lens_reg.pay <= lens_reg.pay + 8'h01;
        default: lens_reg <= lens_reg;
      endcase
    end
  end

  // ==========================================================
  // Error flags and completion
  assign fmtSet = accept && (
      (st_reg == pfc_pkg::PFC_ST_HDR && idx_reg == 8'h00
        && inData[5:4] != `PFC_GFI_M8 && inData[5:4] != `PFC_GFI_M128)
    || st_reg == pfc_pkg::PFC_ST_FIXED
    || (st_reg == pfc_pkg::PFC_ST_ADDR && (inData[7:4] > `PFC_BCD_MAX
        || (rem_reg >= 8'h02 && inData[3:0] > `PFC_BCD_MAX)
        || (rem_reg == 8'h01 && inData[3:0] != 4'h0)))
    || (inLast && !endOk));
  assign lenSet = accept && (
      (st_reg == pfc_pkg::PFC_ST_ULEN && inData[7:6] != 2'h0)
    || (st_reg == pfc_pkg::PFC_ST_FLEN && (inData[7] || inData[6:0] > `PFC_FAC_MAX)));
  assign intSet = accept && inLast && tyEnd == pfc_pkg::PFC_TY_INTR
               && (payEnd == 8'h00 || payEnd > `PFC_INT_MAX);
  assign cudSet = accept && inLast && tyEnd == pfc_pkg::PFC_TY_CLEAR && payEnd != 8'h00
               && (!ctrl_reg[`PFC_CTRL_FAST] || payEnd > `PFC_CUD_MAX);
  assign done_next = (done_reg && !clrPulse) || (accept && inLast);

  // Sticky flags: a set in the clearing cycle survives
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fmtErr_reg <= 1'b0;
      lenErr_reg <= 1'b0;
      intErr_reg <= 1'b0;
      cudErr_reg <= 1'b0;
      done_reg <= 1'b0;
      inReady <= 1'b0;
    end else begin
      fmtErr_reg <= (fmtErr_reg && !clrPulse) || fmtSet;
      lenErr_reg <= (lenErr_reg && !clrPulse) || lenSet;
      intErr_reg <= (intErr_reg && !clrPulse) || intSet;
      cudErr_reg <= (cudErr_reg && !clrPulse) || cudSet;
      done_reg <= done_next;
      inReady <= !done_next; // Holds the stream until software writes the clear bit of CTRL
    end
  end

  pfc_diag_map u_diag (
    .mclk(mclk),
    .arst_n(arst_n),
    .cause(cause_reg),
    .diagIn(diag_reg),
    .localEvt(ctrl_reg[`PFC_CTRL_LOCAL]),
    .diagOut(diagOut)
  );

  // ==========================================================
  // AXI4-Lite slave
  assign wrGo = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wMask = {{8{wStrb_reg[3]}}, {8{wStrb_reg[2]}}, {8{wStrb_reg[1]}}, {8{wStrb_reg[0]}}};
  assign wrHit = (awAddr_reg == `PFC_A_CTRL) || (awAddr_reg == `PFC_A_ENCCFG);
  assign clrPulse = wrGo && awAddr_reg == `PFC_A_CTRL && wMask[`PFC_CTRL_CLR]
                 && wData_reg[`PFC_CTRL_CLR];

  // Address and data are taken in either order, answer after both
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PFC_RESP_OK;
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awAddr_reg <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (wrGo) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? `PFC_RESP_OK : `PFC_RESP_ERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Writable settings with byte lanes honoured
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= `PFC_CTRL_RST;
      enc_reg <= '0;
    end else if (wrGo && awAddr_reg == `PFC_A_CTRL) begin
      ctrl_reg <= (ctrl_reg & ~wMask[1:0]) | (wData_reg[1:0] & wMask[1:0]);
    end else if (wrGo && awAddr_reg == `PFC_A_ENCCFG) begin
      enc_reg <= (enc_reg & ~wMask[25:0]) | (wData_reg[25:0] & wMask[25:0]);
    end
  end

  // Read mux; the encoder output is formed on the fly from its settings
  always_comb begin
    rdHit = 1'b1;
    rdWord = 32'h0000_0000;
    case ({s_axi_araddr[7:2], 2'h0})
      `PFC_A_CTRL: rdWord = {30'h0, ctrl_reg};
      `PFC_A_STAT: rdWord = {21'h0, ty_reg, 2'h0, hdr_reg.mod128, cudErr_reg, intErr_reg,
                             lenErr_reg, fmtErr_reg, done_reg};
      `PFC_A_HDR: rdWord = {14'h0, hdr_reg};
      `PFC_A_DIAG: rdWord = {8'h0, diagOut, diag_reg, cause_reg};
      `PFC_A_LENS: rdWord = {3'h0, lens_reg};
      `PFC_A_ENCCFG: rdWord = {6'h0, enc_reg};
      `PFC_A_ENCOUT: begin
        rdWord[31:24] = {enc_reg.calling, enc_reg.called};
        rdWord[23:16] = {enc_reg.h.pr, enc_reg.h.more};
        rdWord[15:8] = enc_reg.h.mod128 ? {enc_reg.h.ps, 1'b0}
                     : {enc_reg.h.pr[2:0], enc_reg.h.more, enc_reg.h.ps[2:0], 1'b0};
        rdWord[7:0] = {enc_reg.h.q, enc_reg.h.d,
                       enc_reg.h.mod128 ? `PFC_GFI_M128 : `PFC_GFI_M8, 4'h0};
      end
      default: rdHit = 1'b0;
    endcase
  end

  // One read in flight; answer the cycle after the address is taken
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PFC_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdWord;
      s_axi_rresp <= rdHit ? `PFC_RESP_OK : `PFC_RESP_ERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_first_octet;
    accept && st_reg == pfc_pkg::PFC_ST_HDR && idx_reg == 8'h00 && !inLast;
  endsequence
  sequence s_mod8_data_type;
    accept && st_reg == pfc_pkg::PFC_ST_HDR && idx_reg == 8'h02 && !inData[0];
  endsequence
  a_format_select: assert property (s_first_octet |=> hdr_reg.mod128 ==
    ($past(inData[5:4]) == `PFC_GFI_M128)) else $error("format code not decoded");
  a_qd_flags: assert property (s_first_octet |=> hdr_reg.q == $past(inData[7])
    && hdr_reg.d == $past(inData[6])) else $error("qualifier or delivery flag lost");
  a_mod8_data_fields: assert property (s_mod8_data_type and (!hdr_reg.mod128 && !inLast)
    |=> hdr_reg.pr == {4'h0, $past(inData[7:5])} && hdr_reg.ps == {4'h0, $past(inData[3:1])}
    && st_reg == pfc_pkg::PFC_ST_PAY) else $error("modulo 8 data header misparsed");
  a_util_len_flag: assert property (accept && st_reg == pfc_pkg::PFC_ST_ULEN
    && inData[7:6] != 2'h0 |=> lenErr_reg) else $error("overlong utility length missed");
  a_fac_len_flag: assert property (accept && st_reg == pfc_pkg::PFC_ST_FLEN
    && inData[6:0] > `PFC_FAC_MAX |=> lenErr_reg) else $error("overlong facility length missed");
  a_int_empty_flag: assert property (accept && inLast && st_reg == pfc_pkg::PFC_ST_HDR
    && idx_reg == 8'h02 && inData == `PFC_TY_INT |=> intErr_reg && done_reg)
    else $error("empty interrupt not flagged");
  a_overrun_flag: assert property (accept && inLast && st_reg == pfc_pkg::PFC_ST_UTIL
    && rem_reg > 8'h01 |=> fmtErr_reg ##1 fmtErr_reg) else $error("overrun not flagged");
  a_done_stalls: assert property (accept && inLast |=> !inReady && done_reg)
    else $error("stream not held after packet end");
endmodule // pfc_codec

// [sim/pfc_peer.sv]
// =====================
// Peer exchange terminal model: offers one packet on the octet stream.
// Assumes the bench calls send just after a rising edge of mclk.
`timescale 1ns/1ps
module pfc_peer (
  // Clock
  input wire logic mclk,
  // Octet stream
  output logic inValid,
  output logic [7:0] inData,
  output logic inLast,
  input wire logic inReady
);
  // Idle bus at time zero
  initial begin
    inValid = 1'b0;
    inData = 8'h00;
    inLast = 1'b0;
  end
  // Octet i sits at v[8*(n-1-i)]; each is held until taken
  task automatic send(input logic [95:0] v, input int n, input bit slow);
    logic t;
    for (int i = 0; i < n; i++) begin
      if (slow && i > 0) begin
        inValid <= 1'b0;
        inData <= ~inData; // Released bus never shows stale data
        @(posedge mclk);
      end
      inValid <= 1'b1;
      inData <= v[8*(n-1-i) +: 8];
      inLast <= (i == n - 1);
      do begin
        #1 t = inReady;
        @(posedge mclk);
      end while (!t);
    end
    inValid <= 1'b0;
    inLast <= 1'b0;
    inData <= ~inData;
  endtask
endmodule // pfc_peer

// [sim/pfc_codec_tb.sv]
// =====================
// Bench: packets from the peer model, results read over AXI4-Lite.
// Assumes response ready lines may stay high throughout.
`timescale 1ns/1ps
module pfc_codec_tb;
  logic mclk, arst_n, inValid, inLast, inReady, awvalid, awready, wvalid, wready;
  logic bvalid, arvalid, arready, rvalid;
  logic [7:0] inData, awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] dg [9] = '{32'h00050000, 32'h00050172, 32'h00056f72, 32'h00057070,
    32'h00057f7f, 32'h00058071, 32'h0005ff71, 32'h01050505, 32'h00014040};
  int err_total = 0;
  int checks_done = 0;
  pfc_peer i_pfc_peer (.mclk(mclk), .inValid(inValid), .inData(inData), .inLast(inLast),
    .inReady(inReady));
  pfc_codec i_pfc_codec (.mclk(mclk), .arst_n(arst_n), .inValid(inValid), .inData(inData),
    .inLast(inLast), .inReady(inReady), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1));
  // =====================
  // Bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      #1 ta = awready & awvalid;
      tw = wready & wvalid;
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (awvalid & ~ta | wvalid & ~tw);
    do begin
      #1 tb = bvalid;
      rs = bresp;
      @(posedge mclk);
    end while (!tb);
  endtask
  task automatic rg(input logic [7:0] a);
    logic t;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      #1 t = arready;
      @(posedge mclk);
    end while (!t);
    arvalid <= 1'b0;
    do begin
      #1 t = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge mclk);
    end while (!t);
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Clear flags, send a packet, poll STAT until done; rd holds STAT
  task automatic pk(input logic [95:0] v, input int n, input logic [7:0] c, input bit s);
    wr(8'h00, {24'h0, c | 8'h04});
    i_pfc_peer.send(v, n, s);
    rd = 32'h0;
    for (int i = 0; i < 9 && rd[0] !== 1'b1; i++) rg(8'h04);
  endtask
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // =====================
  // Clock, watchdog, tests
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    #60000;
    err_total++;
    end_sim();
  end
  initial begin
    {arst_n, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    rg(8'h04);
    cmp(rd, 32'h0);
    wr(8'h04, 32'h1);
    cmp({30'h0, rs}, 32'h2);
    rg(8'h1c);
    cmp(rd, 32'h0);
    cmp({30'h0, rs}, 32'h2);
    wr(8'h14, 32'h010ed555);
    rg(8'h18);
    cmp(rd, 32'h4355aaa0);
    wr(8'h14, 32'h00014283);
    rg(8'h18);
    cmp(rd, 32'h000bb650);
    $display("Test bus done");
    pk(40'h9000b6aa55, 5, 8'h00, 1'b1);
    cmp(rd, 32'h101);
    rg(8'h08);
    cmp(rd, 32'h24283);
    rg(8'h10);
    cmp(rd, 32'h2);
    pk(40'h6000aa5511, 5, 8'h00, 1'b0);
    cmp(rd, 32'h121);
    rg(8'h08);
    cmp(rd, 32'h1d555);
    pk(32'h200005fe, 4, 8'h00, 1'b0);
    cmp(rd, 32'h521);
    rg(8'h08);
    cmp(rd, 32'hbf80);
    pk(24'h1000e1, 3, 8'h00, 1'b0);
    cmp(rd, 32'h401);
    rg(8'h08);
    cmp(rd, 32'h380);
    pk(24'h100023, 3, 8'h00, 1'b0);
    cmp(rd, 32'h209);
    $display("Test headers done");
    foreach (dg[i]) begin
      pk({24'h100013, dg[i][23:8]}, 5, dg[i][31:24], 1'b0);
      rg(8'h0c);
      cmp(rd, {8'h00, dg[i][7:0], dg[i][15:8], dg[i][23:16]});
    end
    pk(88'h1000130500211230_01aa00, 11, 8'h00, 1'b0);
    cmp(rd, 32'h301);
    rg(8'h10);
    cmp(rd, 32'h4208000);
    pk(64'h1000130500211235, 8, 8'h00, 1'b0);
    cmp(rd, 32'h303);
    pk(64'h10001305000003aa, 8, 8'h00, 1'b0);
    cmp(rd, 32'h303);
    pk(64'h100013050000c0ee, 8, 8'h00, 1'b0);
    cmp(rd, 32'h307);
    pk(72'h100013050000000055, 9, 8'h00, 1'b0);
    cmp(rd, 32'h311);
    pk(72'h100013050000000055, 9, 8'h02, 1'b0);
    cmp(rd, 32'h301);
    $display("Test clear done");
    end_sim();
  end
endmodule // pfc_codec_tb
